// ==== src/sar_pkg.sv ====
// Shared constants and carriers for the converter strobe interface and sequencer.
// Assumes one 100 MHz clock; host strobes arrive asynchronously on pins.
package sar_pkg;
  localparam int res_width = 13;
  localparam int byte_width = 8;
  localparam int sample_gap = 4;
  localparam int trial_count = 12;
  localparam logic [3:0] trial_last = 4'hb;
  localparam logic [2:0] sample_last = 3'h4;
  localparam logic [12:0] latch_reset = 13'h0000;
  localparam logic [12:0] pos_full_code = 13'h0fff;
  localparam logic [12:0] neg_full_code = 13'h1000;

  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
  } strobe_type;

  typedef struct packed {
    logic sample_pos;
    logic sample_neg;
    logic cmp_strobe;
  } analog_ctl_type;

  typedef enum logic [2:0] {
    st_idle,
    st_sample,
    st_sign,
    st_trial,
    st_update
  } seq_state_type;
endpackage

// ==== src/pin_sync.sv ====
// Three-stage pin synchroniser; a change counts once stages two and three agree.
// Assumes the input is asynchronous to mclk_i.
`timescale 1ns/1ns
module pin_sync
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // Pin
  input wire logic pin_i,
  output logic level_o
);
  logic [2:0] stage;
  logic [2:0] next_stage;
  logic level;
  logic next_level;

  always_comb
  begin
    next_stage = {stage[1:0], pin_i};
    next_level = level;
    if (stage[1] == stage[2])
    begin
      next_level = stage[2];
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      stage <= 3'h7;
      level <= 1'h1;
    end
    else
    begin
      stage <= next_stage;
      level <= next_level;
    end
  end

  assign level_o = level;
endmodule

// ==== src/sar_strobe_ctrl.sv ====
// Strobe interface, conversion sequencer and output latch of a 12-bit plus sign converter.
// Assumes a bus master on cs/rd/wr pins and an external comparator and DAC.
`timescale 1ns/1ns
module sar_strobe_ctrl
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // Host strobes and variant strap
  input wire sar_pkg::strobe_type strobe_i,
  input wire logic byte_bus_i,
  // Analog front end
  input wire logic comparator_i,
  output sar_pkg::analog_ctl_type analog_o,
  output logic [11:0] dac_code_o,
  // Host outputs
  output logic [12:0] data_o,
  output logic [7:0] data_bus_low_lines_o,
  output logic data_oe_o,
  output logic conversion_done_irq_n_o,
  output logic ready_n_o,
  output logic busy_o
);
  import sar_pkg::*;

  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic rd_q;
  logic wr_q;
  logic next_rd_q;
  logic next_wr_q;

  pin_sync u_cs (.mclk_i(mclk_i), .srst_i(srst_i), .pin_i(strobe_i.cs_n), .level_o(cs_n));
  pin_sync u_rd (.mclk_i(mclk_i), .srst_i(srst_i), .pin_i(strobe_i.rd_n), .level_o(rd_n));
  pin_sync u_wr (.mclk_i(mclk_i), .srst_i(srst_i), .pin_i(strobe_i.wr_n), .level_o(wr_n));

  logic rd_act;
  logic wr_act;
  logic start_fall;
  logic read_fall;
  logic read_rise;
  assign rd_act = ~cs_n & ~rd_n;
  assign wr_act = ~cs_n & ~wr_n;
  assign start_fall = wr_act & ~wr_q;
  assign read_fall = rd_act & ~rd_q;
  assign read_rise = ~rd_act & rd_q;

  seq_state_type state;
  seq_state_type next_state;
  logic [3:0] bit_idx;
  logic [3:0] next_bit_idx;
  logic [2:0] gap_cnt;
  logic [2:0] next_gap_cnt;
  logic sign;
  logic next_sign;
  logic [11:0] sar;
  logic [11:0] next_sar;
  logic [12:0] latch;
  logic [12:0] next_latch;
  logic [12:0] shown;
  logic [12:0] next_shown;
  logic irq_n;
  logic next_irq_n;
  logic ptr_low;
  logic next_ptr_low;
  logic wr_held;
  logic next_wr_held;
  analog_ctl_type actl;
  analog_ctl_type next_actl;

  // Sign then magnitude, complemented when negative; a negative trial word maps onto the lower half of the code span
  function automatic logic [12:0] to_code(input logic s, input logic [11:0] m);
    to_code = {s, s ? ~m : m};
  endfunction

  always_comb
  begin
    next_state = state;
    next_bit_idx = bit_idx;
    next_gap_cnt = gap_cnt;
    next_sign = sign;
    next_sar = sar;
    next_latch = latch;
    next_irq_n = irq_n;
    next_ptr_low = ptr_low;
    next_wr_held = wr_held & wr_act;
    next_actl = '0;
    next_rd_q = rd_act;
    next_wr_q = wr_act;
    case (state)
      st_sample:
      begin
        next_gap_cnt = gap_cnt + 3'h1;
        next_actl.sample_neg = (gap_cnt == sample_last);
        if (gap_cnt == sample_last)
        begin
          next_state = st_sign;
        end
      end
      st_sign:
      begin
        next_actl.cmp_strobe = 1'h1;
        // Comparator high means the input is above zero, so the sign bit is its inverse
        next_sign = ~comparator_i;
        next_sar = 12'h800;
        next_bit_idx = trial_last;
        next_state = st_trial;
      end
      st_trial:
      begin
        next_actl.cmp_strobe = 1'h1;
        // Decision taken on the last edge of the period, after input spikes decay
        next_sar[bit_idx] = comparator_i ^ sign;
        if (bit_idx == 4'h0)
        begin
          next_state = st_update;
        end
        else
        begin
          next_sar[bit_idx - 4'h1] = 1'h1;
          next_bit_idx = bit_idx - 4'h1;
        end
      end
      st_update:
      begin
        next_latch = to_code(sign, sar);
        next_ptr_low = 1'h0;
        // Still-held start or read suppresses the interrupt entirely
        next_irq_n = wr_held | rd_act;
        next_state = st_idle;
      end
      default:
      begin
        next_state = st_idle;
      end
    endcase
    if (read_fall)
    begin
      next_irq_n = 1'h1;
    end
    if (read_rise && byte_bus_i)
    begin
      next_ptr_low = ~ptr_low;
    end
    if (start_fall)
    begin
      // Restart aborts the running conversion, as with a second early strobe
      next_irq_n = 1'h1;
      next_wr_held = 1'h1;
      next_state = st_sample;
      next_gap_cnt = 3'h1;
      next_actl.sample_pos = 1'h1;
    end
  end

  // Frozen only while a read overlaps its own start, so permanent reads still follow the latch
  always_comb
  begin
    next_shown = shown;
    if (!rd_act || read_fall || !wr_held)
    begin
      next_shown = latch;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      state <= st_idle;
      bit_idx <= 4'h0;
      gap_cnt <= 3'h0;
      sign <= 1'h0;
      sar <= 12'h000;
      latch <= latch_reset;
      shown <= latch_reset;
      irq_n <= 1'h1;
      ptr_low <= 1'h0;
      wr_held <= 1'h0;
      actl <= '0;
      rd_q <= 1'h0;
      wr_q <= 1'h0;
    end
    else
    begin
      state <= next_state;
      bit_idx <= next_bit_idx;
      gap_cnt <= next_gap_cnt;
      sign <= next_sign;
      sar <= next_sar;
      latch <= next_latch;
      shown <= next_shown;
      irq_n <= next_irq_n;
      ptr_low <= next_ptr_low;
      wr_held <= next_wr_held;
      actl <= next_actl;
      rd_q <= next_rd_q;
      wr_q <= next_wr_q;
    end
  end

  assign analog_o = actl;
  assign dac_code_o = sar;
  assign data_o = shown;
  // High byte sign extended, low byte plain
  assign data_bus_low_lines_o = ptr_low ? shown[7:0] : {{3{shown[12]}}, shown[12:8]};
  assign data_oe_o = rd_act;
  assign conversion_done_irq_n_o = irq_n;
  assign ready_n_o = (state != st_update);
  assign busy_o = (state != st_idle);

  property p_irq_after_update;
    @(posedge mclk_i) disable iff (srst_i)
      $fell(irq_n) |-> $past(state) == st_update && latch == $past(to_code(sign, sar));
  endproperty
  a_irq_after_update: assert property (p_irq_after_update) else $error("interrupt without latch update");
  property p_ready_one;
    @(posedge mclk_i) disable iff (srst_i) !ready_n_o |=> ready_n_o;
  endproperty
  a_ready_one: assert property (p_ready_one) else $error("ready low longer than one cycle");
  property p_no_irq_long_start;
    @(posedge mclk_i) disable iff (srst_i) (state == st_update && wr_held) |=> irq_n;
  endproperty
  a_no_irq_long_start: assert property (p_no_irq_long_start) else $error("irq on long start");
  property p_no_irq_read_low;
    @(posedge mclk_i) disable iff (srst_i) (state == st_update && rd_act) |=> irq_n;
  endproperty
  a_no_irq_read_low: assert property (p_no_irq_read_low) else $error("irq with read held");
  property p_irq_clear;
    @(posedge mclk_i) disable iff (srst_i) (read_fall || start_fall) |=> irq_n;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("interrupt not cleared");
  property p_ready_update;
    @(posedge mclk_i) disable iff (srst_i) !ready_n_o |=> !$stable(latch) || state == st_idle;
  endproperty
  a_ready_update: assert property (p_ready_update) else $error("ready without update");
  property p_shown_frozen;
    @(posedge mclk_i) disable iff (srst_i) (rd_act && rd_q && wr_held) |=> $stable(shown);
  endproperty
  a_shown_frozen: assert property (p_shown_frozen) else $error("data moved during read");
  property p_sample_gap;
    @(posedge mclk_i) disable iff (srst_i) (actl.sample_pos ##1 !start_fall [*4]) |-> actl.sample_neg;
  endproperty
  a_sample_gap: assert property (p_sample_gap) else $error("negative sample not 4 clocks later");
  property p_ptr_reset;
    @(posedge mclk_i) disable iff (srst_i) (state == st_update && !read_rise) |=> !ptr_low;
  endproperty
  a_ptr_reset: assert property (p_ptr_reset) else $error("byte pointer not reset");
  property p_conv_len;
    @(posedge mclk_i) disable iff (srst_i) start_fall ##1 !start_fall [*8] |-> ##[1:20] state == st_update;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion did not end");
  c_irq: cover property (@(posedge mclk_i) $fell(irq_n));
  c_long_start: cover property (@(posedge mclk_i) state == st_update && wr_held);
  c_low_byte: cover property (@(posedge mclk_i) read_rise && ptr_low);
endmodule

// ==== sim/sar_host_model.sv ====
// Bus master model driving select, read and start strobes on the converter pins.
// Assumes the bench calls its tasks from the mclk_i domain; lines move 1 ns after an edge.
`timescale 1ns/1ns
module sar_host_model
(
  // Clock
  input wire logic mclk_i,
  // Strobes to the device
  output sar_pkg::strobe_type strobe_o
);
  import sar_pkg::*;
  strobe_type idle = 3'b111;
  initial strobe_o = 3'b111;
  // One low pulse after four resting edges, so the pin filter sees every release
  task automatic pulse(input strobe_type s, input int len);
    repeat (4) @(posedge mclk_i);
    #1 strobe_o = s;
    repeat (len) @(posedge mclk_i);
    #1 strobe_o = idle;
  endtask
  // New resting level, e.g. select and read tied low permanently
  task automatic set_idle(input strobe_type s);
    @(posedge mclk_i);
    #1 idle = s;
    strobe_o = s;
  endtask
endmodule

// ==== sim/sar_strobe_ctrl_tb_top.sv ====
// Self-checking bench for the converter strobe interface against a small result model.
// Assumes the host model drives strobes and the bench holds the comparator per conversion.
`timescale 1ns/1ns
module sar_strobe_ctrl_tb_top;
  import sar_pkg::*;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic byte_bus_i = 1'b0;
  logic comparator_i = 1'b0;
  strobe_type strobe;
  analog_ctl_type analog;
  logic [11:0] dac_code;
  logic [12:0] data;
  logic [7:0] data_low;
  logic data_oe, irq_n, ready_n, busy;
  logic irq_seen = 1'b0;
  logic irq_last = 1'b1;
  logic ready_seen = 1'b0;
  logic [12:0] exp = 13'h0000;
  logic [12:0] nxt = 13'h0000;
  int n_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int pos_at = 0;

  initial forever #5 mclk_i = ~mclk_i;

  sar_host_model sar_host_model_i (.mclk_i(mclk_i), .strobe_o(strobe));
  sar_strobe_ctrl sar_strobe_ctrl_i (.mclk_i(mclk_i), .srst_i(srst_i), .strobe_i(strobe),
    .byte_bus_i(byte_bus_i), .comparator_i(comparator_i), .analog_o(analog), .dac_code_o(dac_code),
    .data_o(data), .data_bus_low_lines_o(data_low), .data_oe_o(data_oe),
    .conversion_done_irq_n_o(irq_n), .ready_n_o(ready_n), .busy_o(busy));

  task automatic check(input logic [31:0] got, input logic [31:0] want);
    num_checks++;
    if (got !== want)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, want);
    end
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Hangs are cut at a ceiling far above the few hundred cycles the run needs
  always @(posedge mclk_i)
  begin
    cycles <= cycles + 1;
    if (irq_n === 1'b0 && irq_last === 1'b1) irq_seen <= 1'b1;
    irq_last <= irq_n;
    if (ready_n === 1'b0) ready_seen <= 1'b1;
    if (analog.sample_pos === 1'b1) pos_at <= cycles;
    if (analog.sample_neg === 1'b1) check(cycles - pos_at, 4);
    if (cycles == 3000)
    begin
      n_errors++;
      test_done();
    end
  end

  // Constant comparator level gives a full-scale code of known sign
  task automatic arm;
    @(posedge mclk_i);
    #1 comparator_i = 1'($urandom);
    nxt = comparator_i ? pos_full_code : neg_full_code;
    irq_seen = 1'b0;
    ready_seen = 1'b0;
  endtask

  task automatic wait_irq;
    int i;
    i = 0;
    while (irq_n !== 1'b0 && i < 60)
    begin
      @(posedge mclk_i);
      i++;
    end
    #1 exp = nxt;
    check(irq_n, 0);
    check(ready_seen, 1);
    check(data, exp);
  endtask

  task automatic reset_dut(input logic byte_mode);
    @(posedge mclk_i);
    #1 srst_i = 1'b1;
    byte_bus_i = byte_mode;
    repeat (5) @(posedge mclk_i);
    #1 srst_i = 1'b0;
    repeat (4) @(posedge mclk_i);
    #1;
  endtask

  initial
  begin
    void'($urandom(32'hfc219011));
    reset_dut(1'b0);
    check({irq_n, ready_n, data_oe, busy, data}, 17'h18000);
    arm();
    sar_host_model_i.pulse(3'b010, 4);
    wait_irq();
    sar_host_model_i.set_idle(3'b001);
    repeat (5) @(posedge mclk_i);
    #1;
    check({irq_n, data_oe, data}, {2'b11, exp});
    sar_host_model_i.set_idle(3'b111);
    arm();
    sar_host_model_i.pulse(3'b010, 40);
    repeat (30) @(posedge mclk_i);
    #1 exp = nxt;
    check({irq_seen, ready_seen, data}, {2'b01, exp});
    arm();
    sar_host_model_i.set_idle(3'b000);
    repeat (4) @(posedge mclk_i);
    #1;
    check(data, exp);
    sar_host_model_i.set_idle(3'b111);
    wait_irq();
    arm();
    sar_host_model_i.set_idle(3'b000);
    repeat (40) @(posedge mclk_i);
    sar_host_model_i.set_idle(3'b111);
    repeat (30) @(posedge mclk_i);
    #1 exp = nxt;
    check({irq_seen, ready_seen, data}, {2'b01, exp});
    sar_host_model_i.set_idle(3'b001);
    repeat (2)
    begin
      arm();
      sar_host_model_i.pulse(3'b000, 4);
      repeat (30) @(posedge mclk_i);
      #1 exp = nxt;
      check({irq_seen, data_oe, data}, {2'b01, exp});
    end
    sar_host_model_i.set_idle(3'b111);
    reset_dut(1'b1);
    arm();
    sar_host_model_i.pulse(3'b000, 4);
    wait_irq();
    sar_host_model_i.pulse(3'b000, 4);
    check(data_low, {{3{exp[12]}}, exp[12:8]});
    sar_host_model_i.pulse(3'b000, 4);
    check(data_low, exp[7:0]);
    arm();
    wait_irq();
    sar_host_model_i.pulse(3'b000, 4);
    check(data_low, {{3{exp[12]}}, exp[12:8]});
    repeat (40) @(posedge mclk_i);
    test_done();
  end
endmodule
